/* File: core/pcrl_pkg.sv */
// Constants and shared types for the printer command and result logic
package pcrl_pkg;

  // ------------------------------------------------------------
  // Register map (byte addresses) and status bits
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_OPWORD = 8'h00;
  localparam logic [7:0] ADDR_RESULT = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_MASK   = 8'h0c;
  localparam logic [7:0] ADDR_STATE  = 8'h10;
  localparam int         ST_DONE     = 0;
  localparam int         ST_EXC      = 1;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ------------------------------------------------------------
  // Operation word fields and codes
  // ------------------------------------------------------------
  localparam logic [3:0]  OP_PRINT     = 4'h4;
  localparam logic [3:0]  OP_PRINT_OVR = 4'h5;
  localparam logic [3:0]  OP_MOVE      = 4'ha;
  localparam logic [3:0]  OP_MOVE_OVR  = 4'hb;
  localparam logic [23:0] OP_TEST_WORD = 24'h800000;
  localparam logic [3:0]  MC_NONE      = 4'h0;
  localparam logic [3:0]  MC_CHAN1     = 4'h1;
  localparam logic [3:0]  MC_NEXT      = 4'hd;
  localparam logic [3:0]  MC_SINGLE    = 4'he;
  localparam logic [3:0]  MC_DOUBLE    = 4'hf;

  // ------------------------------------------------------------
  // Result descriptor: bit n sits at vector index 24-n
  // ------------------------------------------------------------
  localparam int RB_CPL1  = 23;
  localparam int RB_EXC   = 22;
  localparam int RB_NRDY  = 21;
  localparam int RB_DERR  = 20;
  localparam int RB_EOP   = 17;
  localparam int RB_CS_HI = 16;
  localparam int RB_CS_LO = 14;
  localparam int RB_PIM   = 11;
  localparam int RB_XLU   = 10;
  localparam int RB_X_HI  = 21;
  localparam int RB_X_LO  = 8;
  localparam int RB_CPL17 = 7;
  localparam int RB_ID_HI = 6;
  localparam int RB_ID_LO = 1;
  localparam logic [23:0] RESULT_RST = 24'h000000;

  typedef enum logic [1:0] {PCRL_IDLE, PCRL_PRINT, PCRL_MOVE, PCRL_FIN} pcrl_state_t;

endpackage : pcrl_pkg

/* File: core/pcrl_top.sv */
// Printer command decode, sequencing and result descriptor with AXI4-Lite access
//
// The implementer's own choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
module pcrl_top #(
  parameter logic [5:0] CTRL_ID = 6'h2d  // Identity code, value arbitrary
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       ce,
  input  wire logic [7:0] s_axi_awaddr,
  input  wire logic       s_axi_awvalid,
  output logic            s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0] s_axi_wstrb,
  input  wire logic       s_axi_wvalid,
  output logic            s_axi_wready,
  output logic [1:0]      s_axi_bresp,
  output logic            s_axi_bvalid,
  input  wire logic       s_axi_bready,
  input  wire logic [7:0] s_axi_araddr,
  input  wire logic       s_axi_arvalid,
  output logic            s_axi_arready,
  output logic [31:0]     s_axi_rdata,
  output logic [1:0]      s_axi_rresp,
  output logic            s_axi_rvalid,
  input  wire logic       s_axi_rready,
  input  wire logic       prt_ready,
  input  wire logic       prt_eop,
  input  wire logic       prt_paper_moving,
  input  wire logic       prt_data_error,
  input  wire logic       prt_xlat_loaded,
  input  wire logic       prt_print_done,
  input  wire logic       prt_move_done,
  input  wire logic [3:0] prt_cs_pos,
  output logic            prt_print_req,
  output logic            prt_move_req,
  output logic [3:0]      prt_move_code,
  output logic            irq
);
  import pcrl_pkg::*;

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] strb_mask(input logic [3:0] s);
    strb_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction : strb_mask

  // Exception summary is derived here so no path can forget it
  function automatic logic [23:0] build_res(input logic nr, input logic de, input logic ep,
                                            input logic [2:0] cs, input logic pm,
                                            input logic xu, input logic [5:0] id);
    logic [23:0] r;
    r = RESULT_RST;
    r[RB_CPL1]  = 1'b1;
    r[RB_CPL17] = 1'b1;
    r[RB_NRDY]  = nr;
    r[RB_DERR]  = de;
    r[RB_EOP]   = ep;
    r[RB_CS_HI:RB_CS_LO] = cs;
    r[RB_PIM]   = pm;
    r[RB_XLU]   = xu;
    r[RB_ID_HI:RB_ID_LO] = id;
    r[RB_EXC]   = |r[RB_X_HI:RB_X_LO];
    build_res = r;
  endfunction : build_res

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  logic [10:0] pin_s1;
  logic [10:0] pin_s2;
  // Selector switch is static, so a plain two-stage copy suffices
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_s1 <= 11'h000;
      pin_s2 <= 11'h000;
    end else if (ce) begin
      pin_s1 <= {prt_ready, prt_eop, prt_paper_moving, prt_data_error, prt_xlat_loaded,
                 prt_print_done, prt_move_done, prt_cs_pos};
      pin_s2 <= pin_s1;
    end
  end
  logic       rdy_s, eop_s, pim_s, derr_s, xl_s, pdone_s, mdone_s;
  logic [3:0] pos_s;
  assign {rdy_s, eop_s, pim_s, derr_s, xl_s, pdone_s, mdone_s, pos_s} = pin_s2;

  // ------------------------------------------------------------
  // AXI4-Lite slave
  // ------------------------------------------------------------
  logic        aw_held, w_held, next_aw_held, next_w_held;
  logic [7:0]  aw_addr, next_aw_addr, ar_addr_n;
  logic [31:0] w_data, next_w_data, next_rdata, rd_val;
  logic [3:0]  w_strb, next_w_strb;
  logic        next_bvalid, next_rvalid, next_awready, next_wready, next_arready;
  logic [1:0]  next_bresp, next_rresp;
  logic        wr_fire, rd_fire, wr_hit, rd_hit;

  logic [23:0]  opword, result;
  logic [1:0]   status, mask;
  pcrl_state_t  st;

  assign wr_fire = aw_held && w_held && !s_axi_bvalid;
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign wr_hit  = aw_addr <= ADDR_MASK && aw_addr[1:0] == 2'h0;
  assign ar_addr_n = s_axi_araddr;
  assign rd_hit  = ar_addr_n <= ADDR_STATE && ar_addr_n[1:0] == 2'h0;

  // Read mux; narrow registers sit in the low bits
  always_comb begin
    unique case (ar_addr_n)
      ADDR_OPWORD: rd_val = {8'h00, opword};
      ADDR_RESULT: rd_val = {8'h00, result};
      ADDR_STATUS: rd_val = {30'h0, status};
      ADDR_MASK:   rd_val = {30'h0, mask};
      ADDR_STATE:  rd_val = {22'h0, st != PCRL_IDLE, pin_s2[10:6], pos_s};
      default:     rd_val = 32'h0;
    endcase
  end

  // Address and data are latched separately so either may come first
  always_comb begin
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held  = w_held;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_bvalid  = s_axi_bvalid;
    next_bresp   = s_axi_bresp;
    next_rvalid  = s_axi_rvalid;
    next_rresp   = s_axi_rresp;
    next_rdata   = s_axi_rdata;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (wr_fire) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (rd_fire) begin
      next_rvalid = 1'b1;
      next_rdata  = rd_val;
      next_rresp  = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    next_awready = !next_aw_held && !next_bvalid;
    next_wready  = !next_w_held && !next_bvalid;
    next_arready = !next_rvalid;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
      w_held <= 1'b0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= RESP_OKAY;
      s_axi_rdata <= 32'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_arready <= 1'b0;
    end else if (ce) begin
      aw_held <= next_aw_held;
      aw_addr <= next_aw_addr;
      w_held <= next_w_held;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_rvalid <= next_rvalid;
      s_axi_rresp <= next_rresp;
      s_axi_rdata <= next_rdata;
      s_axi_awready <= next_awready;
      s_axi_wready <= next_wready;
      s_axi_arready <= next_arready;
    end
  end

  // ------------------------------------------------------------
  // Operation sequencer and result registers
  // ------------------------------------------------------------
  pcrl_state_t next_st;
  logic [23:0] next_opword, next_result;
  logic [1:0]  next_status, next_mask, st_set, st_clr;
  logic [3:0]  code, next_code, top, mc;
  logic        is_test, next_is_test, is_prt, next_is_prt, ovr, next_ovr;
  logic        nrdy, next_nrdy, derr, next_derr, eop, next_eop, pim, next_pim;
  logic [2:0]  cs, next_cs;
  logic        next_print_req, next_move_req, next_irq, start, eop_rep, skip_ord;
  logic [31:0] wmask;

  assign wmask   = strb_mask(w_strb);
  assign start   = wr_fire && aw_addr == ADDR_OPWORD && st == PCRL_IDLE;
  assign top     = w_data[23:20];
  assign mc      = w_data[19:16];
  // A skip to a channel (codes 1 to D) hides the page end
  assign skip_ord = code >= MC_CHAN1 && code <= MC_NEXT;
  assign eop_rep  = eop && !ovr && !skip_ord;

  always_comb begin
    next_st = st;
    next_opword = opword;
    next_result = result;
    next_code = code;
    next_is_test = is_test;
    next_is_prt = is_prt;
    next_ovr = ovr;
    next_nrdy = nrdy;
    next_derr = derr;
    next_eop = eop;
    next_pim = pim;
    next_cs = cs;
    next_print_req = prt_print_req;
    next_move_req = prt_move_req;
    next_mask = mask;
    st_set = 2'h0;
    st_clr = 2'h0;
    if (wr_fire && aw_addr == ADDR_MASK) begin
      next_mask = (mask & ~wmask[1:0]) | (w_data[1:0] & wmask[1:0]);
    end
    if (wr_fire && aw_addr == ADDR_STATUS) begin
      st_clr = w_data[1:0] & wmask[1:0];
    end
    unique case (st)
      PCRL_IDLE: begin
        // Operation word writes while busy are answered but ignored
        if (start) begin
          next_opword = w_data[23:0];
          next_is_test = w_data[23:0] == OP_TEST_WORD;
          next_is_prt = top == OP_PRINT || top == OP_PRINT_OVR;
          next_ovr = top == OP_PRINT_OVR || top == OP_MOVE_OVR;
          next_code = mc;
          if (next_ovr && eop_s && (mc == MC_SINGLE || mc == MC_DOUBLE)) begin
            next_code = MC_CHAN1;
          end
          next_nrdy = 1'b0;
          next_derr = 1'b0;
          next_eop = eop_s;
          next_pim = 1'b0;
          next_cs = 3'h0;
          next_st = PCRL_FIN;
          if (next_is_test) begin
            // Test never waits on the printer
            next_nrdy = !rdy_s;
            next_pim = pim_s;
            next_cs = 3'(pos_s - 4'h1);
            next_code = MC_NONE;
          end else if (!(next_is_prt || top == OP_MOVE || top == OP_MOVE_OVR)) begin
            next_code = MC_NONE;
          end else if (!rdy_s) begin
            next_nrdy = 1'b1;
          end else if (next_is_prt) begin
            next_st = PCRL_PRINT;
            next_print_req = 1'b1;
          end else if (next_code != MC_NONE) begin
            next_st = PCRL_MOVE;
            next_move_req = 1'b1;
          end
        end
      end
      PCRL_PRINT: begin
        next_derr = derr | derr_s;
        next_eop = eop | eop_s;
        if (!rdy_s) begin
          next_nrdy = 1'b1;
          next_print_req = 1'b0;
          next_st = PCRL_FIN;
        end else if (pdone_s) begin
          next_print_req = 1'b0;
          if (code == MC_NONE) begin
            next_st = PCRL_FIN;
          end else begin
            next_move_req = 1'b1;
            next_st = PCRL_MOVE;
          end
        end
      end
      PCRL_MOVE: begin
        next_eop = eop | eop_s;
        if (!rdy_s || mdone_s) begin
          next_nrdy = !rdy_s;
          next_move_req = 1'b0;
          next_st = PCRL_FIN;
        end
      end
      PCRL_FIN: begin
        next_result = build_res(nrdy, derr, eop_rep, cs, pim,
                                (is_test || is_prt) && !xl_s,
                                is_test ? CTRL_ID : 6'h00);
        st_set = {next_result[RB_EXC], 1'b1};
        next_st = PCRL_IDLE;
      end
    endcase
    // A new event wins over a clear in the same cycle
    next_status = (status & ~st_clr) | st_set;
    next_irq = |(next_status & next_mask);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= PCRL_IDLE;
      opword <= 24'h000000;
      result <= RESULT_RST;
      code <= MC_NONE;
      is_test <= 1'b0;
      is_prt <= 1'b0;
      ovr <= 1'b0;
      nrdy <= 1'b0;
      derr <= 1'b0;
      eop <= 1'b0;
      pim <= 1'b0;
      cs <= 3'h0;
      status <= 2'h0;
      mask <= 2'h0;
      prt_print_req <= 1'b0;
      prt_move_req <= 1'b0;
      prt_move_code <= MC_NONE;
      irq <= 1'b0;
    end else if (ce) begin
      st <= next_st;
      opword <= next_opword;
      result <= next_result;
      code <= next_code;
      is_test <= next_is_test;
      is_prt <= next_is_prt;
      ovr <= next_ovr;
      nrdy <= next_nrdy;
      derr <= next_derr;
      eop <= next_eop;
      pim <= next_pim;
      cs <= next_cs;
      status <= next_status;
      mask <= next_mask;
      prt_print_req <= next_print_req;
      prt_move_req <= next_move_req;
      prt_move_code <= next_code;
      irq <= next_irq;
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  logic res_we;
  assign res_we = ce && st == PCRL_FIN;

  property p_cpl;
    @(posedge clk) disable iff (rst) res_we |=> result[RB_CPL1] && result[RB_CPL17];
  endproperty
  a_cpl: assert property (p_cpl) else $error("completion bits missing");

  property p_exc;
    @(posedge clk) disable iff (rst)
      res_we |=> result[RB_EXC] == (|result[RB_X_HI:RB_X_LO]);
  endproperty
  a_exc: assert property (p_exc) else $error("exception summary wrong");

  property p_test_now;
    @(posedge clk) disable iff (rst)
      ce && start && w_data[23:0] == OP_TEST_WORD |=> st == PCRL_FIN ##1 st == PCRL_IDLE;
  endproperty
  a_test_now: assert property (p_test_now) else $error("test waited");

  property p_nrdy_abort;
    @(posedge clk) disable iff (rst)
      ce && st == PCRL_PRINT && !rdy_s |=> st == PCRL_FIN && nrdy && !prt_print_req;
  endproperty
  a_nrdy_abort: assert property (p_nrdy_abort) else $error("not ready not ended");

  property p_cs;
    @(posedge clk) disable iff (rst)
      res_we && is_test |=> result[RB_CS_HI:RB_CS_LO] == $past(cs);
  endproperty
  a_cs: assert property (p_cs) else $error("charset code wrong");

  property p_id;
    @(posedge clk) disable iff (rst)
      res_we && is_test |=> result[RB_ID_HI:RB_ID_LO] == CTRL_ID && !result[0];
  endproperty
  a_id: assert property (p_id) else $error("control id wrong");

  property p_eop_hide;
    @(posedge clk) disable iff (rst) res_we && (ovr || skip_ord) |=> !result[RB_EOP];
  endproperty
  a_eop_hide: assert property (p_eop_hide) else $error("page end not hidden");

  property p_ovr_skip;
    @(posedge clk) disable iff (rst)
      ce && start && (top == OP_MOVE_OVR) && eop_s && rdy_s && (mc == MC_SINGLE || mc == MC_DOUBLE)
      |=> prt_move_req && prt_move_code == MC_CHAN1;
  endproperty
  a_ovr_skip: assert property (p_ovr_skip) else $error("override skip missing");

  property p_zero_bits;
    @(posedge clk) disable iff (rst)
      res_we |=> result[19:18] == 2'h0 && result[13:12] == 2'h0 && result[9:8] == 2'h0
                 && !result[0];
  endproperty
  a_zero_bits: assert property (p_zero_bits) else $error("reserved bit set");

  property p_irq;
    @(posedge clk) disable iff (rst) ce |=> irq == |(status & mask);
  endproperty
  a_irq: assert property (p_irq) else $error("irq mismatch");

endmodule : pcrl_top
`default_nettype wire

/* File: verif/pcrl_prt_model.sv */
// Printer mechanism model answering print and paper-motion requests
`timescale 1ns/1ps
`default_nettype none
module pcrl_prt_model (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       slow,
  input  wire logic       print_req,
  input  wire logic       move_req,
  input  wire logic [3:0] move_code,
  output logic            print_done,
  output logic            move_done,
  output logic [7:0]      n_print,
  output logic [7:0]      n_move,
  output logic [3:0]      last_code
);
  logic [5:0] pc;
  logic [5:0] mc;
  logic [5:0] dly;
  // Slow mode stands in for a long mechanical line or skip
  assign dly = slow ? 6'h14 : 6'h02;
  // Done rises after the delay and falls once the request is gone
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pc <= '0;
      mc <= '0;
      print_done <= 1'b0;
      move_done <= 1'b0;
      n_print <= '0;
      n_move <= '0;
      last_code <= '0;
    end else begin
      pc <= print_req && !print_done ? pc + 6'h01 : 6'h00;
      mc <= move_req && !move_done ? mc + 6'h01 : 6'h00;
      if (!print_req) begin
        print_done <= 1'b0;
      end else if (pc == dly && !print_done) begin
        print_done <= 1'b1;
        n_print <= n_print + 8'h01;
      end
      if (!move_req) begin
        move_done <= 1'b0;
      end else if (mc == dly && !move_done) begin
        move_done <= 1'b1;
        n_move <= n_move + 8'h01;
        last_code <= move_code;
      end
    end
  end
endmodule : pcrl_prt_model
`default_nettype wire

/* File: verif/pcrl_top_bench.sv */
// Self-checking bench for the printer command and result logic
`timescale 1ns/1ps
`default_nettype none
module pcrl_top_bench;
  import pcrl_pkg::*;
  localparam logic [5:0] ID = 6'h15;  // Identity value, arbitrary
  logic        clk = 1'b0;
  logic        rst;
  logic [7:0]  awaddr, araddr, n_pr, n_mv;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, irq;
  logic        rdy, eop, pim, derr, xl, slow, pq, mq, pd, md;
  logic [3:0]  pos, mcode, lcode;
  int          n_fail = 0;
  int          check_count = 0;

  // ----------------------------------------
  // Clock, design and printer model
  // ----------------------------------------
  always #2.5 clk = ~clk;
  pcrl_top #(.CTRL_ID(ID)) uut (.clk(clk), .rst(rst), .ce(1'b1),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .prt_ready(rdy), .prt_eop(eop), .prt_paper_moving(pim), .prt_data_error(derr),
    .prt_xlat_loaded(xl), .prt_print_done(pd), .prt_move_done(md), .prt_cs_pos(pos),
    .prt_print_req(pq), .prt_move_req(mq), .prt_move_code(mcode), .irq(irq));
  pcrl_prt_model pm (.clk(clk), .rst(rst), .slow(slow), .print_req(pq), .move_req(mq),
    .move_code(mcode), .print_done(pd), .move_done(md), .n_print(n_pr), .n_move(n_mv),
    .last_code(lcode));

  // ----------------------------------------
  // Reporting and bus tasks
  // ----------------------------------------
  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask : chk

  task automatic hang;
    n_fail++;
    $display("unexpected at %0t: wait ran out", $time);
    stop_test();
  endtask : hang

  // Response ready stays high, so one call never lowers what the next raises
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int i;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    if (i == 50) hang();
    r = bresp;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int i;
    araddr <= a;
    arvalid <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    if (i == 50) hang();
    d = rdata;
    r = rresp;
  endtask : rd

  // Expected descriptor, bit n at index 24-n
  function automatic logic [23:0] rdesc(input logic nr, de, ep, pm, xu,
                                        input logic [2:0] cs, input logic [5:0] id);
    logic [23:0] r;
    r = '0;
    r[RB_CPL1] = 1'b1;
    r[RB_CPL17] = 1'b1;
    r[RB_NRDY] = nr;
    r[RB_DERR] = de;
    r[RB_EOP] = ep;
    r[RB_CS_HI:RB_CS_LO] = cs;
    r[RB_PIM] = pm;
    r[RB_XLU] = xu;
    r[RB_ID_HI:RB_ID_LO] = id;
    r[RB_EXC] = |r[RB_X_HI:RB_X_LO];
    return r;
  endfunction : rdesc

  // Start an operation, poll for done within lim reads, check and clear
  task automatic run_op(input logic [23:0] op, input logic [23:0] ex, input int lim);
    logic [31:0] d;
    logic [1:0]  r;
    int          i;
    repeat (3) @(posedge clk);
    wr(ADDR_OPWORD, {8'h00, op}, r);
    for (i = 0; i < lim; i++) begin
      rd(ADDR_STATUS, d, r);
      if (d[ST_DONE]) break;
    end
    if (i == lim) hang();
    rd(ADDR_RESULT, d, r);
    chk(d, {8'h00, ex}, "result descriptor");
    wr(ADDR_STATUS, 32'h3, r);
  endtask : run_op

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic s_regs;
    logic [31:0] d;
    logic [1:0]  r;
    rd(ADDR_RESULT, d, r);
    chk(d, 32'h0, "result after reset");
    rd(8'h14, d, r);
    chk({d[29:0], r}, {30'h0, RESP_SLVERR}, "unmapped read");
    wr(8'h14, 32'h1, r);
    chk({30'h0, r}, {30'h0, RESP_SLVERR}, "unmapped write");
    run_op(24'h200000, rdesc(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 3'h0, 6'h0), 3);
  endtask : s_regs

  // Every selector position, status pins varied; the printer may stay not ready
  task automatic s_test;
    int p;
    for (p = 1; p <= 8; p++) begin
      pos <= p[3:0];
      pim <= p[0];
      xl <= p[1];
      rdy <= !p[2];
      eop <= p[3];
      run_op(OP_TEST_WORD, rdesc(p[2], 1'b0, p[3], p[0], !p[1], 3'(p - 1), ID), 3);
    end
    pim <= 1'b0;
    xl <= 1'b1;  // Host loads the translator to match the set read back
    rdy <= 1'b1;
    eop <= 1'b0;
  endtask : s_test

  // One op with expected motion code c and expected page-end report re
  task automatic pcase(input logic [23:0] op, input logic e, dd, x,
                       input logic [3:0] c, input logic re);
    logic [7:0] m0;
    logic [7:0] p0;
    m0 = n_mv;
    p0 = n_pr;
    eop <= e;
    derr <= dd;
    xl <= x;
    run_op(op, rdesc(1'b0, dd, re, 1'b0, !x, 3'h0, 6'h0), 200);
    chk({24'h0, n_mv - m0}, {31'h0, c != 4'h0}, "paper motion count");
    chk({24'h0, n_pr - p0}, {31'h0, !op[23]}, "print count");
    if (c != 4'h0) chk({28'h0, lcode}, {28'h0, c}, "motion code");
  endtask : pcase

  task automatic s_motion;
    int c;
    for (c = 0; c < 16; c++) begin
      pcase({4'ha, c[3:0], 16'h0}, c[0], 1'b0, 1'b1, c[3:0], c[0] && c >= 14);
    end
    slow <= 1'b1;
    pcase(24'h4e0000, 1'b1, 1'b0, 1'b1, 4'he, 1'b1);
    pcase(24'h5e0000, 1'b1, 1'b0, 1'b1, 4'h1, 1'b0);
    pcase(24'h5f0000, 1'b0, 1'b0, 1'b1, 4'hf, 1'b0);
    pcase(24'h430000, 1'b1, 1'b1, 1'b0, 4'h3, 1'b0);
    pcase(24'hbf0000, 1'b1, 1'b0, 1'b1, 4'h1, 1'b0);
    pcase(24'hb20000, 1'b1, 1'b0, 1'b1, 4'h2, 1'b0);
    eop <= 1'b0;
    derr <= 1'b0;
  endtask : s_motion

  // Not ready at the start, then dropping in mid-print
  task automatic s_nrdy;
    rdy <= 1'b0;
    run_op(24'h4e0000, rdesc(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 3'h0, 6'h0), 20);
    rdy <= 1'b1;
    fork
      begin
        repeat (14) @(posedge clk);
        rdy <= 1'b0;
      end
    join_none
    run_op(24'h4e0000, rdesc(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 3'h0, 6'h0), 200);
    rdy <= 1'b1;
  endtask : s_nrdy

  task automatic s_irq;
    logic [1:0] r;
    int         i;
    wr(ADDR_MASK, 32'h1, r);
    wr(ADDR_OPWORD, {8'h00, OP_TEST_WORD}, r);
    for (i = 0; i < 20 && irq !== 1'b1; i++) @(posedge clk);
    chk({31'h0, irq}, 32'h1, "irq on unmasked done");
    wr(ADDR_STATUS, 32'h1, r);
    repeat (3) @(posedge clk);
    chk({31'h0, irq}, 32'h0, "irq after clear");
    wr(ADDR_MASK, 32'h0, r);
    wr(ADDR_OPWORD, {8'h00, OP_TEST_WORD}, r);
    repeat (10) @(posedge clk);
    chk({31'h0, irq}, 32'h0, "irq while masked");
  endtask : s_irq

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {rst, bready, rready, rdy, xl} = 5'h1f;
    {awvalid, wvalid, arvalid, eop, pim, derr, slow} = 7'h0;
    {awaddr, araddr, wdata} = '0;
    pos = 4'h1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    s_regs();
    s_test();
    s_motion();
    s_nrdy();
    s_irq();
    stop_test();
  end
endmodule : pcrl_top_bench
`default_nettype wire
